// file: tb/csf_status_bank_sva.sv
// port-level assertion checker for the status flag bank
`timescale 1ns/1ps
module csf_status_bank_sva #(
  parameter int unsigned SCAN_UNIT_CYC = csf_pkg::SCAN_UNIT_CYC
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire csf_pkg::csf_wb_req_s wb_req_i,
  input wire csf_pkg::csf_wb_rsp_s wb_rsp_o,
  input wire csf_pkg::csf_exec_s   exec_i,
  input wire logic                 battery_low_i
);
  import csf_pkg::*;
  // ****************************************************************
  // read tracking
  // ****************************************************************
  logic       take;
  logic       rd_ff;
  logic [5:0] rw_ff;
  logic       rd_st;
  logic       rd_dg;
  logic       rd_le;
  assign take  = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign rd_st = wb_rsp_o.ack && rd_ff && (rw_ff == 6'h00);
  assign rd_dg = wb_rsp_o.ack && rd_ff && (rw_ff == 6'h01);
  assign rd_le = wb_rsp_o.ack && rd_ff && (rw_ff == 6'h03);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ff <= 1'b0;
      rw_ff <= 6'h00;
    end else begin
      rd_ff <= take && !wb_req_i.we;
      rw_ff <= wb_req_i.adr[7:2];
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_take; take |=> wb_rsp_o.ack; endproperty
  property p_ack_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
  property p_dat_idle; !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0000_0000; endproperty
  property p_unused; rd_st |-> !wb_rsp_o.dat[BIT_UNUSED] && wb_rsp_o.dat[31:16] == 16'h0000; endproperty
  property p_diag;
    rd_dg && $past(exec_i.diag_err, 2) |-> wb_rsp_o.dat == {16'h0000, $past(exec_i.diag_code, 2)};
  endproperty
  property p_latest;
    rd_le && $past(exec_i.op_err, 2) |-> wb_rsp_o.dat[15:0] == $past(exec_i.op_addr, 2);
  endproperty
  property p_carry;
    rd_st && $past(exec_i.arith_done, 2) |-> wb_rsp_o.dat[BIT_CARRY] == $past(exec_i.arith_ovf, 2);
  endproperty
  property p_cmp;
    rd_st && $past(exec_i.cmp_done, 2) |-> wb_rsp_o.dat[BIT_LT:BIT_GT] ==
      {$past(exec_i.cmp_lt, 2), $past(exec_i.cmp_eq, 2), $past(exec_i.cmp_gt, 2)};
  endproperty
  property p_timer; rd_st && !$past(exec_i.timer_trig, 2) |-> !wb_rsp_o.dat[BIT_AUX_TIMER]; endproperty
  a_ack_take: assert property (p_ack_take) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  a_dat_idle: assert property (p_dat_idle) else $error("data driven outside ack");
  a_unused: assert property (p_unused) else $error("unused status bits set");
  a_diag: assert property (p_diag) else $error("diagnostic code not stored");
  a_latest: assert property (p_latest) else $error("latest error address wrong");
  a_carry: assert property (p_carry) else $error("carry wrong after arithmetic");
  a_cmp: assert property (p_cmp) else $error("compare flags wrong");
  a_timer: assert property (p_timer) else $error("timer contact set without trigger");
  c_scan: cover property (rd_st && wb_rsp_o.dat[BIT_CONST_SCAN]);
  c_bat: cover property (rd_st && wb_rsp_o.dat[BIT_BAT_HELD]);
  c_latest: cover property (rd_le);
endmodule : csf_status_bank_sva

bind csf_status_bank csf_status_bank_sva #(.SCAN_UNIT_CYC(SCAN_UNIT_CYC)) csf_status_bank_sva_inst (
  .clk_i         (clk_i),
  .rst_i         (rst_i),
  .wb_req_i      (wb_req_i),
  .wb_rsp_o      (wb_rsp_o),
  .exec_i        (exec_i),
  .battery_low_i (battery_low_i)
);

// file: tb/csf_status_bank_tb.sv
// self-checking bench for the status flag bank
`timescale 1ns/1ps
module csf_status_bank_tb;
  import csf_pkg::*;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  csf_wb_req_s req       = '0;
  csf_wb_rsp_s rsp;
  csf_exec_s   ex        = '0;
  csf_exec_s   base      = '0;
  logic        bat       = 1'b0;
  int          err_total = 0;
  int          n_tests   = 0;
  logic [31:0] rdat;
  logic [31:0] st;

  csf_status_bank #(.SCAN_UNIT_CYC(4)) csf_status_bank_inst (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .wb_req_i      (req),
    .wb_rsp_o      (rsp),
    .exec_i        (ex),
    .battery_low_i (bat)
  );

  always #5 clk_i = ~clk_i;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      stop_test();
    end
    rdat = rsp.dat;
    req <= '0;
  endtask : wb

  task automatic rc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000, 4'hF);
    chk(rdat, exp);
  endtask : rc

  task automatic ev(input csf_exec_s e);
    @(posedge clk_i);
    ex <= e | base;
    @(posedge clk_i);
    ex <= base;
  endtask : ev

  // read launched one edge behind the event, so its data is the first to hold that event
  task automatic evrc(input csf_exec_s e, input logic [7:0] adr, input logic [31:0] exp);
    fork
      ev(e);
      begin
        @(posedge clk_i);
        rc(adr, exp);
      end
    join
  endtask : evrc

  function automatic logic [31:0] bm(input int b);
    return 32'h0000_0001 << b;
  endfunction : bm

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 8'h14; a += 4) begin
      rc(8'(a), 32'h0000_0000);
    end
    rc(8'h20, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hF);
    rc(8'h00, 32'h0000_0000);
    $display("test reset done");
    evrc('{diag_err: 1'b1, diag_code: 16'hA5C3, cas_io_err: 1'b1, cas_abn_err: 1'b1,
           io_verify_err: 1'b1, tool_comm_err: 1'b1, default: '0}, 8'h04, 32'h0000_A5C3);
    st = bm(BIT_SELF_CHECK) | bm(BIT_CAS_IO) | bm(BIT_CAS_ABN) | bm(BIT_IO_VERIFY) | bm(BIT_TOOL_COMM);
    rc(8'h00, st);
    wb(1'b1, 8'h00, 32'h0000_0000, 4'hF);
    wb(1'b1, 8'h04, 32'h0000_0000, 4'hF);
    rc(8'h00, st);
    rc(8'h04, 32'h0000_A5C3);
    ev('{sys_init: 1'b1, default: '0});
    $display("test sticky done");
    ev('{op_err: 1'b1, op_addr: 16'h1234, default: '0});
    evrc('{op_err: 1'b1, op_addr: 16'h5678, default: '0}, 8'h0C, 32'h0000_5678);
    rc(8'h08, 32'h0000_1234);
    rc(8'h00, bm(BIT_OP_HELD) | bm(BIT_OP_UNL));
    ev('{instr_done: 1'b1, default: '0});
    rc(8'h00, bm(BIT_OP_HELD));
    ev('{sys_init: 1'b1, default: '0});
    $display("test operation done");
    @(posedge clk_i);
    bat <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(8'h00, bm(BIT_BAT_UNL) | bm(BIT_BAT_HELD));
    @(posedge clk_i);
    bat <= 1'b0;
    repeat (4) @(posedge clk_i);
    rc(8'h00, bm(BIT_BAT_HELD));
    ev('{sys_init: 1'b1, default: '0});
    rc(8'h00, 32'h0000_0000);
    $display("test battery done");
    evrc('{arith_done: 1'b1, arith_ovf: 1'b1, arith_zero: 1'b1, default: '0},
         8'h00, bm(BIT_CARRY) | bm(BIT_EQ));
    evrc('{shift_done: 1'b1, default: '0}, 8'h00, bm(BIT_EQ));
    for (int k = 0; k < 3; k++) begin
      evrc('{cmp_done: 1'b1, cmp_gt: (k == 0), cmp_eq: (k == 1), cmp_lt: (k == 2), default: '0},
           8'h00, bm(BIT_GT + k));
    end
    base.timer_trig = 1'b1;
    ev('{timer_zero: 1'b1, default: '0});
    rc(8'h00, bm(BIT_LT) | bm(BIT_AUX_TIMER));
    base.timer_trig = 1'b0;
    ev(base);
    rc(8'h00, bm(BIT_LT));
    $display("test flags done");
    wb(1'b1, 8'h10, 32'hFFFF_FF02, 4'h1);
    rc(8'h10, 32'h0000_0002);
    wb(1'b1, 8'h14, 32'h0000_0001, 4'h1);
    ev('{scan_start: 1'b1, default: '0});
    repeat (3) @(posedge clk_i);
    ev('{scan_end: 1'b1, default: '0});
    rc(8'h00, bm(BIT_LT));
    ev('{scan_start: 1'b1, default: '0});
    repeat (20) @(posedge clk_i);
    rc(8'h00, bm(BIT_LT) | bm(BIT_CONST_SCAN));
    ev('{scan_end: 1'b1, default: '0});
    wb(1'b1, 8'h14, 32'h0000_0000, 4'hF);
    wb(1'b1, 8'h10, 32'h0000_0000, 4'hF);
    ev('{sys_init: 1'b1, default: '0});
    rc(8'h00, bm(BIT_LT));
    wb(1'b1, 8'h14, 32'h0000_0001, 4'hF);
    repeat (5) @(posedge clk_i);
    rc(8'h00, bm(BIT_LT) | bm(BIT_CONST_SCAN));
    $display("test scan done");
    stop_test();
  end
endmodule : csf_status_bank_tb

// file: verilog/csf_pkg.sv
// constants, register map and carrier types for the controller status flag bank
package csf_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCAN_UNIT_NS  = 100000;
  localparam int unsigned SCAN_UNIT_CYC = SCAN_UNIT_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned WB_AW      = 8;
  localparam int unsigned WB_DW      = 32;
  localparam int unsigned WB_SW      = 4;
  localparam int unsigned FLAG_W     = 16;
  localparam int unsigned DIAG_W     = 16;
  localparam int unsigned ERR_ADDR_W = 16;
  localparam int unsigned SCAN_SET_W = 16;
  localparam int unsigned UNIT_W     = 32;
  localparam int unsigned SCAN_LIM_W = SCAN_SET_W + UNIT_W;
  localparam int unsigned BYTE_W     = 8;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [WB_AW-1:0] REG_STATUS     = 8'h00;
  localparam logic [WB_AW-1:0] REG_DIAG_CODE  = 8'h04;
  localparam logic [WB_AW-1:0] REG_FIRST_ERR  = 8'h08;
  localparam logic [WB_AW-1:0] REG_LATEST_ERR = 8'h0C;
  localparam logic [WB_AW-1:0] REG_SCAN_SET   = 8'h10;
  localparam logic [WB_AW-1:0] REG_SCAN_CTL   = 8'h14;

  // ****************************************************************
  // status word bit positions and the scan control enable bit
  // ****************************************************************
  localparam int unsigned BIT_SELF_CHECK = 0;
  localparam int unsigned BIT_UNUSED     = 1;
  localparam int unsigned BIT_CAS_IO     = 2;
  localparam int unsigned BIT_CAS_ABN    = 3;
  localparam int unsigned BIT_IO_VERIFY  = 4;
  localparam int unsigned BIT_BAT_UNL    = 5;
  localparam int unsigned BIT_BAT_HELD   = 6;
  localparam int unsigned BIT_OP_HELD    = 7;
  localparam int unsigned BIT_OP_UNL     = 8;
  localparam int unsigned BIT_CARRY      = 9;
  localparam int unsigned BIT_GT         = 10;
  localparam int unsigned BIT_EQ         = 11;
  localparam int unsigned BIT_LT         = 12;
  localparam int unsigned BIT_AUX_TIMER  = 13;
  localparam int unsigned BIT_TOOL_COMM  = 14;
  localparam int unsigned BIT_CONST_SCAN = 15;
  localparam int unsigned BIT_SCAN_EN    = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [SCAN_SET_W-1:0] SCAN_SET_RST = 16'h0000;
  localparam logic                  SCAN_EN_RST  = 1'b0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [WB_AW-1:0] adr;
    logic [WB_SW-1:0] sel;
    logic [WB_DW-1:0] dat;
  } csf_wb_req_s;

  typedef struct packed {
    logic             ack;
    logic [WB_DW-1:0] dat;
  } csf_wb_rsp_s;

  typedef struct packed {
    logic                  instr_done;
    logic                  diag_err;
    logic [DIAG_W-1:0]     diag_code;
    logic                  cas_io_err;
    logic                  cas_abn_err;
    logic                  io_verify_err;
    logic                  op_err;
    logic [ERR_ADDR_W-1:0] op_addr;
    logic                  arith_done;
    logic                  arith_ovf;
    logic                  arith_zero;
    logic                  shift_done;
    logic                  shift_carry;
    logic                  cmp_done;
    logic                  cmp_gt;
    logic                  cmp_eq;
    logic                  cmp_lt;
    logic                  timer_trig;
    logic                  timer_zero;
    logic                  tool_comm_err;
    logic                  scan_start;
    logic                  scan_end;
    logic                  sys_init;
  } csf_exec_s;

endpackage : csf_pkg

// file: verilog/csf_scan_mon.sv
// constant-scan overrun monitor for the status flag bank
`timescale 1ns/1ps
module csf_scan_mon #(
  parameter int unsigned UNIT_CYC = csf_pkg::SCAN_UNIT_CYC
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           scan_en_i,
  input  wire logic [csf_pkg::SCAN_SET_W-1:0] scan_set_i,
  input  wire logic                           scan_start_i,
  input  wire logic                           scan_end_i,
  output logic                                overrun_o,
  output logic                                zero_set_o
);
  import csf_pkg::*;

  typedef enum logic {MON_IDLE, MON_TIMING} csf_mon_e;

  typedef struct packed {
    csf_mon_e              state;
    logic [SCAN_LIM_W-1:0] cnt;
    logic                  over;
    logic                  zero;
  } csf_mon_s;

  csf_mon_s              st_ff;
  csf_mon_s              nxt_st;
  logic [SCAN_LIM_W-1:0] limit;

  assign limit = SCAN_LIM_W'(scan_set_i) * SCAN_LIM_W'(UNIT_CYC);

  // ****************************************************************
  // scan timing
  // ****************************************************************
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.over = 1'b0;
    nxt_st.zero = scan_en_i && (scan_set_i == '0); // (R18)
    case (st_ff.state)
      MON_IDLE: begin
        if (scan_en_i && scan_start_i) begin
          nxt_st.state = MON_TIMING;
          nxt_st.cnt   = '0;
        end
      end
      MON_TIMING: begin
        if (!scan_en_i) begin
          nxt_st.state = MON_IDLE;
        end else if (scan_end_i) begin
          // back-to-back scans restart the count at once
          nxt_st.state = scan_start_i ? MON_TIMING : MON_IDLE;
          nxt_st.cnt   = '0;
        end else if (st_ff.cnt == limit) begin
          nxt_st.over  = 1'b1; // (R17)
          nxt_st.state = MON_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      default: begin
        nxt_st.state = MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign overrun_o  = st_ff.over;
  assign zero_set_o = st_ff.zero;

endmodule : csf_scan_mon

// file: verilog/csf_status_bank.sv
// status flag bank of the controller with its classic wishbone register slave
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
// Functional notes
// (R01) writes from bus or program never change any flag; only internal events do
// (R02) flags stay internal; no flag is driven to an output port
// (R03) self-diagnosis error sets self-check flag and stores its diagnostic code
// (R04) error in an i/o type cassette sets the cassette i/o fault flag
// (R05) error in any application cassette sets the cassette abnormal flag
// (R06) failed i/o verification sets the i/o verify fault flag
// (R07) unlatched battery flag follows battery failure, whatever the warning setting
// (R08) held battery flag latches, clears only on reset or system initialisation
// (R09) held operation flag latches; first error address recorded only once
// (R10) unlatched operation flag pulses per error; latest address always overwritten; the code holds the flag until the next instr_done
// (R11) carry set on arithmetic overflow or underflow, updated by shift instructions
// (R12) greater-than flag set when comparison finds first operand larger
// (R13) equal flag set on equal comparison or zero arithmetic result
// (R14) less-than flag set when comparison finds first operand smaller
// (R15) aux timer contact set at count zero, cleared when trigger goes off
// (R16) tool port communication error sets the tool port fault flag
// (R17) constant scan longer than configured time sets constant-scan fault flag
// (R18) constant-scan time configured as zero also sets constant-scan fault flag
// (R19) momentary flags hold until the next instruction that updates them
// (R20) unused status bit always reads as zero
module csf_status_bank #(
  parameter int unsigned SCAN_UNIT_CYC = csf_pkg::SCAN_UNIT_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire csf_pkg::csf_wb_req_s wb_req_i,
  output csf_pkg::csf_wb_rsp_s      wb_rsp_o,
  input  wire csf_pkg::csf_exec_s   exec_i,
  input  wire logic                 battery_low_i
);
  import csf_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic                  ack;
    logic [WB_DW-1:0]      rdat;
    logic                  bat_meta;
    logic                  bat_sync;
    logic [FLAG_W-1:0]     flags;
    logic [DIAG_W-1:0]     diag;
    logic [ERR_ADDR_W-1:0] first_err;
    logic [ERR_ADDR_W-1:0] latest_err;
    logic [SCAN_SET_W-1:0] scan_set;
    logic                  scan_en;
  } csf_bank_s;

  localparam csf_bank_s BANK_RST = '{
    ack:        1'b0,
    rdat:       '0,
    bat_meta:   1'b0,
    bat_sync:   1'b0,
    flags:      '0,
    diag:       '0,
    first_err:  '0,
    latest_err: '0,
    scan_set:   SCAN_SET_RST,
    scan_en:    SCAN_EN_RST
  };

  csf_bank_s st_ff;
  csf_bank_s nxt_st;
  logic      take;
  logic      scan_over;
  logic      scan_zero;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic hits(input logic [WB_AW-1:0] adr,
                                input logic [WB_AW-1:0] off);
    hits = (adr[WB_AW-1:2] == off[WB_AW-1:2]);
  endfunction : hits

  // a new request is taken once; ack drops in the following cycle
  assign take = wb_req_i.cyc && wb_req_i.stb && !st_ff.ack;

  // ****************************************************************
  // constant-scan monitor
  // ****************************************************************
  csf_scan_mon #(
    .UNIT_CYC     (SCAN_UNIT_CYC)
  ) u_scan_mon (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .scan_en_i    (st_ff.scan_en),
    .scan_set_i   (st_ff.scan_set),
    .scan_start_i (exec_i.scan_start),
    .scan_end_i   (exec_i.scan_end),
    .overrun_o    (scan_over),
    .zero_set_o   (scan_zero)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [FLAG_W-1:0] f;
    f      = st_ff.flags;
    nxt_st = st_ff;

    // battery detector is a pin: two stages before use
    nxt_st.bat_meta = battery_low_i;
    nxt_st.bat_sync = st_ff.bat_meta;

    // initialisation clears latched flags; sets below win in the same cycle
    if (exec_i.sys_init) begin
      f[BIT_SELF_CHECK] = 1'b0;
      f[BIT_CAS_IO]     = 1'b0;
      f[BIT_CAS_ABN]    = 1'b0;
      f[BIT_IO_VERIFY]  = 1'b0;
      f[BIT_BAT_HELD]   = 1'b0; // (R08)
      f[BIT_OP_HELD]    = 1'b0;
      f[BIT_TOOL_COMM]  = 1'b0;
      f[BIT_CONST_SCAN] = 1'b0;
    end

    // diagnostics and cassettes
    if (exec_i.diag_err) begin
      f[BIT_SELF_CHECK] = 1'b1; // (R03)
      nxt_st.diag       = exec_i.diag_code; // (R03)
    end
    if (exec_i.cas_io_err) begin
      f[BIT_CAS_IO] = 1'b1; // (R04)
    end
    if (exec_i.cas_abn_err) begin
      f[BIT_CAS_ABN] = 1'b1; // (R05)
    end
    if (exec_i.io_verify_err) begin
      f[BIT_IO_VERIFY] = 1'b1; // (R06)
    end

    // battery: no warning setting gates the unlatched copy
    f[BIT_BAT_UNL] = st_ff.bat_sync; // (R07)
    if (st_ff.bat_sync) begin
      f[BIT_BAT_HELD] = 1'b1; // (R08)
    end

    // operation errors
    if (exec_i.op_err) begin
      if (!st_ff.flags[BIT_OP_HELD]) begin
        nxt_st.first_err = exec_i.op_addr; // (R09)
      end
      f[BIT_OP_HELD]    = 1'b1; // (R09)
      nxt_st.latest_err = exec_i.op_addr; // (R10)
    end
    if (exec_i.instr_done || exec_i.op_err) begin
      f[BIT_OP_UNL] = exec_i.op_err; // (R10) (R19)
    end

    // carry
    if (exec_i.arith_done) begin
      f[BIT_CARRY] = exec_i.arith_ovf; // (R11)
    end else if (exec_i.shift_done) begin
      f[BIT_CARRY] = exec_i.shift_carry; // (R11)
    end

    // comparison results hold until the next updating instruction
    if (exec_i.cmp_done) begin
      f[BIT_GT] = exec_i.cmp_gt; // (R12) (R19)
      f[BIT_EQ] = exec_i.cmp_eq; // (R13) (R19)
      f[BIT_LT] = exec_i.cmp_lt; // (R14) (R19)
    end else if (exec_i.arith_done) begin
      f[BIT_EQ] = exec_i.arith_zero; // (R13) (R19)
    end

    // auxiliary timer: trigger off wins, contact cannot stay on without it
    if (!exec_i.timer_trig) begin
      f[BIT_AUX_TIMER] = 1'b0; // (R15)
    end else if (exec_i.timer_zero) begin
      f[BIT_AUX_TIMER] = 1'b1; // (R15)
    end

    // tool port and constant scan
    if (exec_i.tool_comm_err) begin
      f[BIT_TOOL_COMM] = 1'b1; // (R16)
    end
    if (scan_over) begin
      f[BIT_CONST_SCAN] = 1'b1; // (R17)
    end
    if (scan_zero) begin
      f[BIT_CONST_SCAN] = 1'b1; // (R18)
    end

    f[BIT_UNUSED] = 1'b0; // (R20)
    nxt_st.flags  = f;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    nxt_st.ack  = take;
    nxt_st.rdat = '0;
    if (take && wb_req_i.we) begin
      // flag and address words ignore writes and still answer
      if (hits(wb_req_i.adr, REG_SCAN_SET)) begin
        if (wb_req_i.sel[0]) begin
          nxt_st.scan_set[BYTE_W-1:0] = wb_req_i.dat[BYTE_W-1:0];
        end
        if (wb_req_i.sel[1]) begin
          nxt_st.scan_set[SCAN_SET_W-1:BYTE_W] = wb_req_i.dat[SCAN_SET_W-1:BYTE_W];
        end
      end else if (hits(wb_req_i.adr, REG_SCAN_CTL)) begin
        if (wb_req_i.sel[0]) begin
          nxt_st.scan_en = wb_req_i.dat[BIT_SCAN_EN];
        end
      end // (R01)
    end else if (take) begin
      if (hits(wb_req_i.adr, REG_STATUS)) begin
        nxt_st.rdat = WB_DW'(st_ff.flags); // (R20)
      end else if (hits(wb_req_i.adr, REG_DIAG_CODE)) begin
        nxt_st.rdat = WB_DW'(st_ff.diag);
      end else if (hits(wb_req_i.adr, REG_FIRST_ERR)) begin
        nxt_st.rdat = WB_DW'(st_ff.first_err);
      end else if (hits(wb_req_i.adr, REG_LATEST_ERR)) begin
        nxt_st.rdat = WB_DW'(st_ff.latest_err);
      end else if (hits(wb_req_i.adr, REG_SCAN_SET)) begin
        nxt_st.rdat = WB_DW'(st_ff.scan_set);
      end else if (hits(wb_req_i.adr, REG_SCAN_CTL)) begin
        nxt_st.rdat = WB_DW'(st_ff.scan_en);
      end else begin
        nxt_st.rdat = '0;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= BANK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // only the bus answer leaves the block; flags are read through it alone
  assign wb_rsp_o.ack = st_ff.ack; // (R02)
  assign wb_rsp_o.dat = st_ff.rdat;

endmodule : csf_status_bank
